// ===== hdl/coeff_map.svh
`ifndef COEFF_MAP_SVH
`define COEFF_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_FINE_IMAG3 8'h1d
`define IDX_FINE_REAL0 8'h1e
`define IDX_FINE_REAL1 8'h1f
`define IDX_FINE_REAL2 8'h20
`define IDX_FINE_REAL3 8'h21
`define IDX_ABS_KV_HI 8'h22
`define IDX_ABS_KV_LO 8'h23
`define IDX_DLY_KV_HI 8'h26
`define IDX_DLY_KV_LO 8'h27
`define IDX_ANGLE_SEL 8'h28
`define IDX_ANGLE_STAT 8'h29

// Reset values
`define COEFF_RST 16'h0000
`define KV_HI_RST 8'h00
`define ANGLE_SEL_RST 2'h0

// Field positions
`define KV_HI_MSB 7
`define ANGLE_SEL_MSB 1

// Fixed-point formats
`define COEF_Q_FRAC 14
`define KV_FRAC 16

`endif

// ===== hdl/coeff_pkg.sv
package coeff_pkg;

  // Four fine filter/rectifier samples, channel 0 in the low slot
  typedef struct packed {
    logic [3:0][15:0] ch;
  } fine_samples_s;

  // Fine Clarke results: real sum and channel 3 imaginary term
  typedef struct packed {
    logic signed [19:0] re;
    logic signed [17:0] im3;
  } clarke_out_s;

  // Angle output selector codes
  typedef enum logic [1:0] {
    SEL_DELAY_A,
    SEL_DELAY_B,
    SEL_LPF,
    SEL_ABS
  } angle_sel_e;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage : coeff_pkg

// ===== hdl/fine_clarke_extrap_coeff_regs.sv
`timescale 1ns/100ps
`include "coeff_map.svh"

// Behaviour
// RL1 - Fourth imaginary fine coefficient scales fine filter channel 3.
// RL2 - Four real fine coefficients scale fine channels 0 to 3 respectively.
// RL3 - Clarke coefficients are signed 16-bit Q2.14 values, fourteen fraction bits.
// RL4 - Absolute extrapolation coefficient is 24 bits; bits 23:16 from its high register.
// RL5 - Its bits 15:0 come from the low register; it scales the velocity term.
// RL6 - Delay extrapolator coefficient is 24 bits; bits 23:16 from its high register.
// RL7 - Its bits 15:0 come from the low register; it scales velocity.
// RL8 - Every coefficient register resets to zero.
// RL9 - High bytes of upper registers read zero; indices 0x24 and 0x25 unmapped.
// RL10 - Selector: codes 00 and 01 delay angle, 10 filtered, 11 absolute.
module fine_clarke_extrap_coeff_regs
  import coeff_pkg::*;
#(
  parameter int ANGLE_W = 24,
  parameter int VEL_W = 16
) (
  input wire logic clk_i, // System clock, 10 MHz
  input wire logic resetn_i, // Synchronous reset, active low
  input wire coeff_pkg::apb_req_s apb_i, // APB request signals
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire coeff_pkg::fine_samples_s fine_i, // Fine filter outputs
  input wire logic fine_valid_i, // Fine samples valid
  output coeff_pkg::clarke_out_s clarke_o, // Fine Clarke results
  output logic clarke_valid_o, // Clarke results valid
  input wire logic [ANGLE_W-1:0] abs_angle_i, // Absolute algorithm angle
  input wire logic signed [VEL_W-1:0] abs_vel_i, // Absolute path velocity
  input wire logic [ANGLE_W-1:0] dly_angle_i, // Angle after digital filters
  input wire logic signed [VEL_W-1:0] dly_vel_i, // Filter path velocity
  input wire logic [ANGLE_W-1:0] lpf_angle_i, // Low-pass filtered angle
  output logic [ANGLE_W-1:0] angle_o // Selected angle
);

  localparam int PW = VEL_W + 25;

  logic [15:0] imag3_r;
  logic [3:0][15:0] real_r;
  logic [7:0] abs_kv_hi_r;
  logic [15:0] abs_kv_lo_r;
  logic [7:0] dly_kv_hi_r;
  logic [15:0] dly_kv_lo_r;
  logic [1:0] angle_sel_r;
  logic [31:0] prdata_r;
  logic [23:0] abs_kv;
  logic [23:0] dly_kv;
  logic [7:0] idx;
  logic aligned;
  logic hit;
  logic wr_en;
  logic setup;
  logic [31:0] rd_nxt;
  logic [3:0][17:0] real_prod;
  logic [17:0] imag_prod;
  logic valid_r;
  logic [ANGLE_W-1:0] abs_ext_r;
  logic [ANGLE_W-1:0] dly_ext_r;
  logic [ANGLE_W-1:0] angle_r;
  clarke_out_s clarke_r;
  logic clarke_valid_r;

  // Angle plus velocity scaled by a 24-bit coefficient
  function automatic logic [ANGLE_W-1:0] extrap(
    input logic [ANGLE_W-1:0] ang,
    input logic signed [VEL_W-1:0] vel,
    input logic [23:0] kv
  );
    logic signed [PW-1:0] p;
    p = PW'(vel) * PW'($signed({1'b0, kv}));
    extrap = ang + p[`KV_FRAC +: ANGLE_W];
  endfunction : extrap

  // True when the index names an implemented register
  function automatic logic mapped(input logic [7:0] i);
    case (i)
      `IDX_FINE_IMAG3, `IDX_FINE_REAL0, `IDX_FINE_REAL1,
      `IDX_FINE_REAL2, `IDX_FINE_REAL3, `IDX_ABS_KV_HI,
      `IDX_ABS_KV_LO, `IDX_DLY_KV_HI, `IDX_DLY_KV_LO,
      `IDX_ANGLE_SEL, `IDX_ANGLE_STAT: mapped = 1'b1;
      default: mapped = 1'b0; // RL9
    endcase
  endfunction : mapped

  // Address decode; word aligned accesses only
  always_comb begin
    idx = apb_i.paddr[9:2];
    aligned = (apb_i.paddr[1:0] == 2'h0);
    hit = aligned && mapped(idx);
    setup = apb_i.psel && !apb_i.penable;
    wr_en = apb_i.psel && apb_i.penable && apb_i.pwrite && hit;
  end

  // Zero wait state slave; error on an unmapped access phase
  assign pready_o = 1'b1;
  assign pslverr_o = apb_i.psel && apb_i.penable && !hit;

  // Fine Clarke coefficient registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      imag3_r <= `COEFF_RST; // RL8
      real_r <= {4{`COEFF_RST}}; // RL8
    end else if (wr_en) begin
      case (idx)
        `IDX_FINE_IMAG3: imag3_r <= apb_i.pwdata[15:0];
        `IDX_FINE_REAL0: real_r[0] <= apb_i.pwdata[15:0];
        `IDX_FINE_REAL1: real_r[1] <= apb_i.pwdata[15:0];
        `IDX_FINE_REAL2: real_r[2] <= apb_i.pwdata[15:0];
        `IDX_FINE_REAL3: real_r[3] <= apb_i.pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Velocity coefficient registers; only the low byte of the upper halves is kept
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      abs_kv_hi_r <= `KV_HI_RST; // RL8
      abs_kv_lo_r <= `COEFF_RST; // RL8
      dly_kv_hi_r <= `KV_HI_RST; // RL8
      dly_kv_lo_r <= `COEFF_RST; // RL8
    end else if (wr_en) begin
      case (idx)
        `IDX_ABS_KV_HI: abs_kv_hi_r <= apb_i.pwdata[`KV_HI_MSB:0]; // RL4 RL9
        `IDX_ABS_KV_LO: abs_kv_lo_r <= apb_i.pwdata[15:0]; // RL5
        `IDX_DLY_KV_HI: dly_kv_hi_r <= apb_i.pwdata[`KV_HI_MSB:0]; // RL6 RL9
        `IDX_DLY_KV_LO: dly_kv_lo_r <= apb_i.pwdata[15:0]; // RL7
        default: ;
      endcase
    end
  end

  // Angle selector code
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      angle_sel_r <= `ANGLE_SEL_RST;
    end else if (wr_en && idx == `IDX_ANGLE_SEL) begin
      angle_sel_r <= apb_i.pwdata[`ANGLE_SEL_MSB:0];
    end
  end

  // Read mux; upper bytes and unmapped words read zero
  always_comb begin
    rd_nxt = 32'h0;
    if (aligned) begin
      case (idx)
        `IDX_FINE_IMAG3: rd_nxt = {16'h0, imag3_r};
        `IDX_FINE_REAL0: rd_nxt = {16'h0, real_r[0]};
        `IDX_FINE_REAL1: rd_nxt = {16'h0, real_r[1]};
        `IDX_FINE_REAL2: rd_nxt = {16'h0, real_r[2]};
        `IDX_FINE_REAL3: rd_nxt = {16'h0, real_r[3]};
        `IDX_ABS_KV_HI: rd_nxt = {24'h0, abs_kv_hi_r}; // RL9
        `IDX_ABS_KV_LO: rd_nxt = {16'h0, abs_kv_lo_r};
        `IDX_DLY_KV_HI: rd_nxt = {24'h0, dly_kv_hi_r}; // RL9
        `IDX_DLY_KV_LO: rd_nxt = {16'h0, dly_kv_lo_r};
        `IDX_ANGLE_SEL: rd_nxt = {30'h0, angle_sel_r};
        `IDX_ANGLE_STAT: rd_nxt = 32'(angle_r);
        default: rd_nxt = 32'h0;
      endcase
    end
  end

  // Read data captured in the setup cycle, stable through the access phase
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prdata_r <= 32'h0;
    end else if (setup) begin
      prdata_r <= rd_nxt;
    end
  end

  assign prdata_o = prdata_r;

  // Real fine products, channel k by real coefficient k
  for (genvar k = 0; k < 4; k++) begin : g_real
    q_scale #(.W(16), .FRAC(`COEF_Q_FRAC)) u_real (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .sample_i($signed(fine_i.ch[k])), // RL2
      .coeff_i($signed(real_r[k])), // RL3
      .prod_o(real_prod[k])
    );
  end

  // Imaginary product for channel 3
  q_scale #(.W(16), .FRAC(`COEF_Q_FRAC)) u_imag3 (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sample_i($signed(fine_i.ch[3])), // RL1
    .coeff_i($signed(imag3_r)), // RL3
    .prod_o(imag_prod)
  );

  // Sample valid follows the product stage
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= fine_valid_i;
    end
  end

  // Sum real terms; results held until the next valid set
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      clarke_r <= '0;
      clarke_valid_r <= 1'b0;
    end else begin
      clarke_valid_r <= valid_r;
      if (valid_r) begin
        clarke_r.re <= 20'($signed(real_prod[0])) + 20'($signed(real_prod[1]))
                     + 20'($signed(real_prod[2])) + 20'($signed(real_prod[3])); // RL2
        clarke_r.im3 <= $signed(imag_prod); // RL1
      end
    end
  end

  assign clarke_o = clarke_r;
  assign clarke_valid_o = clarke_valid_r;

  // Assemble the 24-bit velocity coefficients
  assign abs_kv = {abs_kv_hi_r, abs_kv_lo_r}; // RL4 RL5
  assign dly_kv = {dly_kv_hi_r, dly_kv_lo_r}; // RL6 RL7

  // Both extrapolators, recomputed every cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      abs_ext_r <= '0;
      dly_ext_r <= '0;
    end else begin
      abs_ext_r <= extrap(abs_angle_i, abs_vel_i, abs_kv); // RL5
      dly_ext_r <= extrap(dly_angle_i, dly_vel_i, dly_kv); // RL7
    end
  end

  // Angle output selector
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      angle_r <= '0;
    end else begin
      case (angle_sel_e'(angle_sel_r))
        SEL_DELAY_A: angle_r <= dly_ext_r; // RL10
        SEL_DELAY_B: angle_r <= dly_ext_r; // RL10
        SEL_LPF: angle_r <= lpf_angle_i; // RL10
        SEL_ABS: angle_r <= abs_ext_r; // RL10
        default: angle_r <= dly_ext_r;
      endcase
    end
  end

  assign angle_o = angle_r;

endmodule : fine_clarke_extrap_coeff_regs

// ===== hdl/q_scale.sv
`timescale 1ns/100ps
`include "coeff_map.svh"

// Multiplies a signed sample by a Q2.14 coefficient, registered
module q_scale #(
  parameter int W = 16,
  parameter int FRAC = `COEF_Q_FRAC
) (
  input wire logic clk_i, // System clock
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic signed [W-1:0] sample_i, // Filter output
  input wire logic signed [W-1:0] coeff_i, // Q2.14 coefficient
  output logic signed [W+1:0] prod_o // Scaled product
);

  logic signed [2*W-1:0] full;
  logic signed [2*W-1:0] shifted;

  // Full product, then drop the fractional bits
  always_comb begin
    full = sample_i * coeff_i;
    shifted = full >>> FRAC;
  end

  // Output register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prod_o <= '0;
    end else begin
      prod_o <= shifted[W+1:0];
    end
  end

endmodule : q_scale

// ===== testbench/coeff_regs_assertions.sv
`timescale 1ns/100ps
// Port-level checks of the coefficient bank
module coeff_regs_assertions
  import coeff_pkg::*;
#(
  parameter int ANGLE_W = 24
) (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire coeff_pkg::apb_req_s apb_i, // APB request
  input wire logic [31:0] prdata_o, // Read data
  input wire logic pslverr_o, // Error
  input wire logic fine_valid_i, // Samples valid
  input wire coeff_pkg::clarke_out_s clarke_o, // Clarke results
  input wire logic clarke_valid_o, // Results valid
  input wire logic [ANGLE_W-1:0] angle_o // Selected angle
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Phase decodes
  wire setup = apb_i.psel && !apb_i.penable;
  wire acc = apb_i.psel && apb_i.penable;
  property p_clk_lat; fine_valid_i |-> ##2 clarke_valid_o; endproperty
  a_clk_lat: assert property (p_clk_lat) else $error("clarke result late");
  property p_clk_src; clarke_valid_o |-> $past(fine_valid_i, 2); endproperty
  a_clk_src: assert property (p_clk_src) else $error("clarke result unasked");
  property p_clk_hold; !clarke_valid_o |-> $stable(clarke_o); endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clarke result moved");
  property p_rst;
    $rose(resetn_i) |-> angle_o == '0 && prdata_o == 32'h0 && !clarke_valid_o && clarke_o == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_unmap; acc && apb_i.paddr inside {10'h090, 10'h094} |-> pslverr_o; endproperty
  a_unmap: assert property (p_unmap) else $error("no error on hole");
  property p_map; acc && apb_i.paddr inside {10'h074, 10'h09c} |-> !pslverr_o; endproperty
  a_map: assert property (p_map) else $error("error on mapped");
  property p_hi_zero; setup && apb_i.paddr inside {10'h088, 10'h098} |=> prdata_o[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper byte not zero");
  property p_hole_rd; setup && apb_i.paddr inside {10'h090, 10'h094} |=> prdata_o == 32'h0;
  endproperty
  a_hole_rd: assert property (p_hole_rd) else $error("hole read not zero");
  property p_rd_hold; !setup |=> $stable(prdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : coeff_regs_assertions

bind fine_clarke_extrap_coeff_regs coeff_regs_assertions #(.ANGLE_W(ANGLE_W)) u_chk (
  .clk_i, .resetn_i, .apb_i, .prdata_o, .pslverr_o, .fine_valid_i, .clarke_o,
  .clarke_valid_o, .angle_o);

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`include "coeff_map.svh"
// Self-checking bench for the coefficient bank
module tb_top;
  import coeff_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  apb_req_s apb = '0;
  fine_samples_s fine = '0;
  logic fine_valid = 1'b0;
  logic [23:0] a_ang = '0, d_ang = '0, l_ang = '0, ang, exp_a, kva, kvd;
  logic signed [15:0] a_vel = '0, d_vel = '0;
  logic [31:0] prdata, d;
  logic pready, pslverr, clk_v;
  clarke_out_s clarke, exp_c;
  int bad_count = 0;
  int n_compared = 0;
  logic [15:0] shadow [9];
  localparam logic [7:0] IDX [9] = '{`IDX_FINE_IMAG3, `IDX_FINE_REAL0, `IDX_FINE_REAL1,
    `IDX_FINE_REAL2, `IDX_FINE_REAL3, `IDX_ABS_KV_HI, `IDX_ABS_KV_LO, `IDX_DLY_KV_HI,
    `IDX_DLY_KV_LO};

  fine_clarke_extrap_coeff_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fine_i(fine),
    .fine_valid_i(fine_valid), .clarke_o(clarke), .clarke_valid_o(clk_v),
    .abs_angle_i(a_ang), .abs_vel_i(a_vel), .dly_angle_i(d_ang), .dly_vel_i(d_vel),
    .lpf_angle_i(l_ang), .angle_o(ang));

  // 10 MHz clock
  initial forever #50 clk_i = ~clk_i;

  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // One APB transfer; read data checked on reads, error flag always
  task rw(input logic w, input logic [7:0] idx, input logic [31:0] wd, input logic [31:0] er,
          input logic ee);
    int i;
    @(posedge clk_i);
    apb <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      bad_count++;
      finish_test();
    end
    if (!w) chk(prdata, er);
    chk(pslverr, ee);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : rw

  // Q2.14 product, shifted and kept at 18 bits
  function automatic logic [17:0] qmul(logic [15:0] s, logic [15:0] c);
    logic signed [31:0] p;
    p = $signed(s) * $signed(c);
    return p[31:14];
  endfunction : qmul

  // Angle plus velocity scaled by an unsigned coefficient
  function automatic logic [23:0] extrap(logic [23:0] a, logic [15:0] v, logic [23:0] kv);
    logic signed [40:0] p;
    p = $signed(v) * $signed({1'b0, kv});
    return a + p[39:16];
  endfunction : extrap

  // Main sequence
  initial begin
    void'($urandom(32'hcbcdede4));
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 9; k++) rw(1'b0, IDX[k], 32'h0, 32'h0, 1'b0);
    $display("reset test done");
    for (int k = 0; k < 9; k++) begin
      d = $urandom;
      shadow[k] = (k == 5 || k == 7) ? {8'h00, d[7:0]} : d[15:0];
      rw(1'b1, IDX[k], d, 32'h0, 1'b0);
      rw(1'b0, IDX[k], 32'h0, {16'h0, shadow[k]}, 1'b0);
    end
    for (int a = 8'h24; a < 8'h26; a++) begin
      rw(1'b1, a[7:0], $urandom, 32'h0, 1'b1);
      rw(1'b0, a[7:0], 32'h0, 32'h0, 1'b1);
    end
    $display("access test done");
    for (int n = 0; n < 6; n++) begin
      for (int k = 0; k < 5; k++) begin
        shadow[k] = (n == 0) ? 16'h8000 : 16'($urandom);
        rw(1'b1, IDX[k], {16'h0, shadow[k]}, 32'h0, 1'b0);
      end
      fine <= (n == 0) ? {4{16'h8000}} : {$urandom, $urandom};
      fine_valid <= 1'b1;
      @(posedge clk_i);
      fine_valid <= 1'b0;
      for (int i = 0; i < 8 && clk_v !== 1'b1; i++) @(posedge clk_i);
      // A result that never shows counts as a mismatch and ends the run
      if (clk_v !== 1'b1) begin
        bad_count++;
        finish_test();
      end
      exp_c.re = '0;
      for (int k = 0; k < 4; k++) exp_c.re = exp_c.re + $signed(qmul(fine.ch[k], shadow[k+1]));
      exp_c.im3 = qmul(fine.ch[3], shadow[0]);
      chk(clarke.re, exp_c.re);
      chk(clarke.im3, exp_c.im3);
    end
    $display("clarke test done");
    for (int n = 0; n < 8; n++) begin
      kva = 24'($urandom);
      kvd = 24'($urandom);
      rw(1'b1, `IDX_ANGLE_SEL, n % 4, 32'h0, 1'b0);
      rw(1'b0, `IDX_ANGLE_SEL, 32'h0, n % 4, 1'b0);
      rw(1'b1, `IDX_ABS_KV_HI, {24'($urandom), kva[23:16]}, 32'h0, 1'b0);
      rw(1'b1, `IDX_ABS_KV_LO, {16'h0, kva[15:0]}, 32'h0, 1'b0);
      rw(1'b1, `IDX_DLY_KV_HI, {24'h0, kvd[23:16]}, 32'h0, 1'b0);
      rw(1'b1, `IDX_DLY_KV_LO, {16'h0, kvd[15:0]}, 32'h0, 1'b0);
      a_ang <= 24'($urandom);
      d_ang <= 24'($urandom);
      l_ang <= 24'($urandom);
      a_vel <= (n == 1) ? 16'h8000 : 16'($urandom);
      d_vel <= 16'($urandom);
      repeat (4) @(posedge clk_i);
      case (angle_sel_e'(n % 4))
        SEL_LPF: exp_a = l_ang;
        SEL_ABS: exp_a = extrap(a_ang, a_vel, kva);
        default: exp_a = extrap(d_ang, d_vel, kvd);
      endcase
      chk(ang, exp_a);
      rw(1'b0, `IDX_ANGLE_STAT, 32'h0, {8'h0, exp_a}, 1'b0);
    end
    $display("angle test done");
    // Reset in mid-run: written coefficients and selector must clear again
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 9; k++) rw(1'b0, IDX[k], 32'h0, 32'h0, 1'b0);
    // Zero velocity coefficient and delay selection pass the delay angle as is
    chk(ang, d_ang);
    $display("reset retest done");
    finish_test();
  end
endmodule : tb_top
